/* rtl/clock_select_pkg.sv */
/*
 * Constants for the system clock select and divider block: register
 * offsets, field positions, reset values and the main source encoding.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package clock_select_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h004;
	localparam logic [ADDR_W-1:0] CMD_OFF = 12'h008;
	localparam logic [ADDR_W-1:0] CYCLE_OFF = 12'h00c;

	// ----------------------------------------------------------------
	// Clock control fields
	// ----------------------------------------------------------------
	localparam int CTRL_W = 4;
	localparam int SUB_SEL_BIT = 0;
	localparam int MAIN_STOP_BIT = 1;
	localparam int DIV_LO_BIT = 2;
	localparam int DIV_HI_BIT = 3;
	localparam int DIV_CODE_W = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'hc;
	localparam logic [DIV_CODE_W-1:0] DIV_CODE_RESET = 2'h3;

	// ----------------------------------------------------------------
	// Command fields
	// ----------------------------------------------------------------
	localparam int CMD_CERAMIC_BIT = 0;
	localparam int CMD_RC_BIT = 1;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int ST_SRC_LO = 0;
	localparam int ST_SUB_BIT = 2;
	localparam int ST_STOP_BIT = 3;
	localparam int ST_DIV_LO = 4;
	localparam int ST_PHASE_LO = 6;
	localparam int ST_PEND_BIT = 8;

	// ----------------------------------------------------------------
	// Dividers
	// ----------------------------------------------------------------
	localparam int POW2_W = 3;
	localparam logic [POW2_W-1:0] POW2_RESET_M1 = 3'h7;
	localparam int INSTR_DIV = 3;
	localparam int PHASE_W = 2;
	localparam logic [PHASE_W-1:0] INSTR_M1 = 2'h2;
	localparam int CYCLE_W = 16;

	typedef enum logic [1:0] {
		SRC_RING,
		SRC_RC,
		SRC_CERAMIC
	} main_src_e;

endpackage

/* rtl/edge_tick.sv */
/*
 * Rising-edge detector for oscillator levels, one pulse per edge.
 * Assumes the levels are synchronous to clk and slower than clk / 2.
 */
`timescale 1ns/100ps
module edge_tick #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] last_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					last_reg[i] <= 1'b0;
					rise[i] <= 1'b0;
				end else begin
					last_reg[i] <= level[i];
					rise[i] <= level[i] & ~last_reg[i];
				end
			end
		end
	endgenerate

endmodule // edge_tick

/* rtl/tick_divider.sv */
/*
 * Divides a tick stream by a period that is only reloaded at the
 * boundary of the current period, so no output period is ever cut.
 * Assumes tick_in is a one-cycle pulse in the clk domain.
 */
`timescale 1ns/100ps
module tick_divider #(
	parameter int W = 3,
	parameter logic [W-1:0] RESET_M1 = '1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick_in,
	input wire logic [W-1:0] period_m1,
	output logic tick_out,
	output logic [W-1:0] phase
);

	logic [W-1:0] limit_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= '0;
			limit_reg <= RESET_M1;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (phase == limit_reg) begin
					phase <= '0;
					limit_reg <= period_m1;
					tick_out <= 1'b1;
				end else begin
					phase <= phase + 1'b1;
				end
			end
		end
	end

endmodule // tick_divider

/* rtl/system_clock_select_divider.sv */
/*
 * System clock select and divider: picks the main or sub-clock source,
 * divides it by 1, 2, 4 or 8 and by 3 for the instruction clock.
 * Assumes oscillator levels synchronous to clk and an APB master.
 */
`timescale 1ns/100ps
module system_clock_select_divider
	import clock_select_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ring_osc_input,
	input wire logic main_osc_input,
	input wire logic sub_osc_input,
	output logic ring_osc_enable,
	output logic rc_osc_enable,
	output logic ceramic_osc_enable,
	output logic system_clock,
	output logic instruction_clock,
	output logic [PHASE_W-1:0] instruction_phase
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_reg;
	main_src_e main_src_reg;
	main_src_e active_src_reg;
	logic active_sub_reg;
	logic [DIV_CODE_W-1:0] active_div_reg;
	logic [CYCLE_W-1:0] cycle_reg;
	logic [31:0] prdata_next;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic main_stop;
	logic [2:0] src_rise;
	logic src_tick;
	logic sys_tick;
	logic instr_tick;
	logic [POW2_W-1:0] pow2_m1;
	logic [POW2_W-1:0] pow2_phase;
	logic [DIV_CODE_W-1:0] ctrl_div;
	logic pending;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states: every access finishes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	always_comb begin
		mapped = 1'b0;
		unique case (paddr)
			CTRL_OFF, STATUS_OFF, CMD_OFF, CYCLE_OFF: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	assign pslverr = psel & penable & ~mapped;

	assign ctrl_div = ctrl_reg[DIV_HI_BIT:DIV_LO_BIT];
	assign pending = (ctrl_reg[SUB_SEL_BIT] != active_sub_reg) ||
		(ctrl_div != active_div_reg) || (main_src_reg != active_src_reg);

	always_comb begin
		prdata_next = 32'h0;
		unique case (paddr)
			CTRL_OFF: begin
				prdata_next[CTRL_W-1:0] = ctrl_reg;
			end
			STATUS_OFF: begin
				prdata_next[ST_SRC_LO +: 2] = active_src_reg;
				prdata_next[ST_SUB_BIT] = active_sub_reg;
				prdata_next[ST_STOP_BIT] = main_stop;
				prdata_next[ST_DIV_LO +: DIV_CODE_W] = active_div_reg;
				prdata_next[ST_PHASE_LO +: PHASE_W] = instruction_phase;
				prdata_next[ST_PEND_BIT] = pending;
			end
			CYCLE_OFF: begin
				prdata_next[CYCLE_W-1:0] = cycle_reg;
			end
			default: begin
				prdata_next = 32'h0;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= prdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Clock control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_en && paddr == CTRL_OFF) begin
			ctrl_reg <= pwdata[CTRL_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Main source commands
	// ----------------------------------------------------------------
	// Ceramic wins if software sets both command bits in one write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			main_src_reg <= SRC_RING;
		end else if (wr_en && paddr == CMD_OFF) begin
			if (pwdata[CMD_CERAMIC_BIT]) begin
				main_src_reg <= SRC_CERAMIC;
			end else if (pwdata[CMD_RC_BIT]) begin
				main_src_reg <= SRC_RC;
			end
		end
	end

	// ----------------------------------------------------------------
	// Selection taken over at system clock boundaries
	// ----------------------------------------------------------------
	// Switching mid-period would leave a short system clock pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			active_src_reg <= SRC_RING;
			active_sub_reg <= 1'b0;
			active_div_reg <= DIV_CODE_RESET;
		end else if (sys_tick) begin
			active_src_reg <= main_src_reg;
			active_sub_reg <= ctrl_reg[SUB_SEL_BIT];
			active_div_reg <= ctrl_div;
		end
	end

	// Stop bit acts only once the sub-clock really drives the system
	assign main_stop = active_sub_reg & ctrl_reg[MAIN_STOP_BIT];

	// The old source keeps running until the switch boundary is reached
	always_comb begin
		ring_osc_enable = ~main_stop &&
			(main_src_reg == SRC_RING || active_src_reg == SRC_RING);
		rc_osc_enable = ~main_stop &&
			(main_src_reg == SRC_RC || active_src_reg == SRC_RC);
		ceramic_osc_enable = ~main_stop &&
			(main_src_reg == SRC_CERAMIC || active_src_reg == SRC_CERAMIC);
	end

	// ----------------------------------------------------------------
	// Source edges and selection
	// ----------------------------------------------------------------
	edge_tick #(
		.WIDTH(3)
	) u_edges (
		.clk(clk),
		.rstn(rstn),
		.level({sub_osc_input, main_osc_input, ring_osc_input}),
		.rise(src_rise)
	);

	// RC and ceramic sources share the main oscillator pin
	always_comb begin
		if (active_sub_reg) begin
			src_tick = src_rise[2];
		end else if (main_stop) begin
			src_tick = 1'b0;
		end else if (active_src_reg == SRC_RING) begin
			src_tick = src_rise[0];
		end else begin
			src_tick = src_rise[1];
		end
	end

	// ----------------------------------------------------------------
	// System clock divider
	// ----------------------------------------------------------------
	always_comb begin
		unique case (ctrl_div)
			2'h0: pow2_m1 = 3'h0;
			2'h1: pow2_m1 = 3'h1;
			2'h2: pow2_m1 = 3'h3;
			2'h3: pow2_m1 = 3'h7;
		endcase
	end

	tick_divider #(
		.W(POW2_W),
		.RESET_M1(POW2_RESET_M1)
	) u_sys_div (
		.clk(clk),
		.rstn(rstn),
		.tick_in(src_tick),
		.period_m1(pow2_m1),
		.tick_out(sys_tick),
		.phase(pow2_phase)
	);

	// ----------------------------------------------------------------
	// Instruction clock divider
	// ----------------------------------------------------------------
	tick_divider #(
		.W(PHASE_W),
		.RESET_M1(INSTR_M1)
	) u_instr_div (
		.clk(clk),
		.rstn(rstn),
		.tick_in(sys_tick),
		.period_m1(INSTR_M1),
		.tick_out(instr_tick),
		.phase(instruction_phase)
	);

	// ----------------------------------------------------------------
	// Clock outputs and machine cycle count
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			system_clock <= 1'b0;
			instruction_clock <= 1'b0;
		end else begin
			system_clock <= sys_tick;
			instruction_clock <= instr_tick;
		end
	end

	// Wraps silently; software reads it twice if it needs a long span
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cycle_reg <= '0;
		end else if (instr_tick) begin
			cycle_reg <= cycle_reg + 1'b1;
		end
	end

endmodule // system_clock_select_divider

/* test/system_clock_select_divider_assertions.sv */
/* Port checker for the clock select block.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/100ps
module system_clock_select_divider_assertions
	import clock_select_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ring_osc_enable,
	input wire logic rc_osc_enable,
	input wire logic ceramic_osc_enable,
	input wire logic system_clock,
	input wire logic instruction_clock,
	input wire logic [PHASE_W-1:0] instruction_phase
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic acc;
	logic hit;
	assign acc = psel && penable;
	assign hit = paddr inside {CTRL_OFF, STATUS_OFF, CMD_OFF, CYCLE_OFF};
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc && !hit |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && hit |-> !pslverr)
		else $error("error on mapped access");
	a_sys_gap: assert property (system_clock |=> !system_clock [*3])
		else $error("system pulses too close");
	a_instr_gap: assert property (instruction_clock |=> !instruction_clock [*8])
		else $error("instruction pulses too close");
	a_phase_range: assert property (instruction_phase <= INSTR_M1)
		else $error("phase out of range");
	a_phase_step: assert property ($changed(instruction_phase) |-> instruction_phase ==
		($past(instruction_phase) == INSTR_M1 ? 2'h0 : $past(instruction_phase) + 2'h1))
		else $error("phase skipped");
	a_reset_ring: assert property ($rose(rstn) |-> ring_osc_enable && !rc_osc_enable)
		else $error("ring not the main source after reset");
	cover property (acc && !hit);
	cover property (instruction_clock);
	cover property (!ring_osc_enable && !rc_osc_enable && !ceramic_osc_enable);
endmodule // system_clock_select_divider_assertions

bind system_clock_select_divider system_clock_select_divider_assertions chk_inst (.clk, .rstn,
	.psel, .penable, .paddr, .pready, .pslverr, .ring_osc_enable, .rc_osc_enable,
	.ceramic_osc_enable, .system_clock, .instruction_clock, .instruction_phase);

/* test/osc_model.sv */
/* Oscillator model: ring, main pin and sub-clock levels.
   Assumes clk is the block clock; levels change after its edges. */
`timescale 1ns/100ps
module osc_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ring_en,
	input wire logic main_en,
	output logic ring,
	output logic main,
	output logic sub
);
	// Half periods 2, 3, 5 clk: all slower than clk / 2
	int cr, cm, cs;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{cr, cm, cs} <= '0;
			{ring, main, sub} <= '0;
		end else begin
			// A stopped oscillator freezes at its last level
			cr <= ring_en ? (cr == 1 ? 0 : cr + 1) : cr;
			cm <= main_en ? (cm == 2 ? 0 : cm + 1) : cm;
			cs <= cs == 4 ? 0 : cs + 1;
			ring <= ring ^ (ring_en && cr == 1);
			main <= main ^ (main_en && cm == 2);
			sub <= sub ^ (cs == 4);
		end
	end
endmodule // osc_model

/* test/system_clock_select_divider_test.sv */
/* Bench for the clock select block over APB.
   Assumes ring period 4, main 6, sub 10 clk from osc_model. */
`timescale 1ns/100ps
module system_clock_select_divider_test;
	import clock_select_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic ring_osc_input, main_osc_input, sub_osc_input, ring_osc_enable, rc_osc_enable;
	logic ceramic_osc_enable, system_clock, instruction_clock;
	logic [PHASE_W-1:0] instruction_phase;
	int failures = 0, checks = 0, cyc = 0, p, q;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
	initial begin
		forever #2 clk = ~clk;
	end
	system_clock_select_divider system_clock_select_divider_inst (.clk, .rstn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ring_osc_input,
		.main_osc_input, .sub_osc_input, .ring_osc_enable, .rc_osc_enable,
		.ceramic_osc_enable, .system_clock, .instruction_clock, .instruction_phase);
	osc_model osc_model_inst (.clk, .rstn, .ring_en(ring_osc_enable),
		.main_en(rc_osc_enable | ceramic_osc_enable), .ring(ring_osc_input),
		.main(main_osc_input), .sub(sub_osc_input));
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Three periods each time: a new ratio only lands at a boundary
	task meas(input bit ins, output int n);
		for (int i = 0; i < 3; i++) begin
			do @(posedge clk); while ((ins ? instruction_clock : system_clock) !== 1'b1);
			n = 0;
			do begin @(posedge clk); n++; end
			while ((ins ? instruction_clock : system_clock) !== 1'b1 && n < 400);
		end
	endtask
	task complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1;
		apb(0, CTRL_OFF, 0); `CHK("ctrl", 32'hc, rd)
		meas(0, p); `CHK("sys ring/8", 32, p)
		meas(1, p); `CHK("instr", 96, p)
		apb(0, CYCLE_OFF, 0);
		q = rd;
		meas(1, p); `CHK("instr again", 96, p)
		apb(0, CYCLE_OFF, 0); `CHK("cycles", q + 6, rd)
		$display("test reset done");
		for (int s = 0; s < 3; s++) begin
			// Source switches only at /8: a /1 switch may give a short first period
			if (s > 0) begin
				apb(1, CMD_OFF, s == 1 ? 2 : 1);
				meas(0, p); `CHK("main/8", 48, p)
			end
			for (int c = 0; c < 4; c++) begin
				apb(1, CTRL_OFF, c << 2);
				meas(0, p); `CHK("div", (s ? 6 : 4) << c, p)
			end
			apb(0, STATUS_OFF, 0); `CHK("src", s[1:0], rd[1:0])
			`CHK("rc en", s == 1, rc_osc_enable)
			`CHK("cer en", s == 2, ceramic_osc_enable)
			$display("test source %0d done", s);
		end
		apb(1, CTRL_OFF, 32'hd);
		meas(0, p); `CHK("sub/8", 80, p)
		meas(1, p); `CHK("instr sub", 240, p)
		apb(1, CTRL_OFF, 1);
		meas(0, p); `CHK("sub/1", 10, p)
		apb(1, CTRL_OFF, 3);
		meas(0, p); `CHK("sub stop", 10, p)
		`CHK("main off", 3'h0, {ring_osc_enable, rc_osc_enable, ceramic_osc_enable})
		apb(0, 12'h010, 0); `CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		$display("test sub clock done");
		rstn <= 0;
		repeat (3) @(posedge clk);
		`CHK("phase rst", 2'h0, instruction_phase)
		rstn <= 1;
		apb(0, CTRL_OFF, 0); `CHK("ctrl again", 32'hc, rd)
		meas(0, p); `CHK("ring again", 32, p)
		$display("test second reset done");
		complete_run();
	end
endmodule // system_clock_select_divider_test
